/* File: rtl/sfb_bridge.sv */
// Serial to exchange-area frame bridge with its receive FIFO
// What this block does
// - Output area: ID, length n, n payload bytes, then zero padding.
// - Input area: ID, length, received bytes, rest reads zero.
// - Each published frame advances the input ID by one.
// - Length byte in the input area only when the option is on.
// - Receive frame end chosen by gap, fixed length or delimiters.
// - Gap mode: timer restarts per byte; expiry closes the frame.
// - Gap mode with CRC: check all but last two bytes, drop on mismatch.
// - Fixed mode: end at count or gap; only full-length frames kept.
// - Fixed mode with CRC: length checked first, then CRC, failing frames dropped.
// - Delimiter mode: need start and end byte without gap, else drop.
// - Delimiter mode keeps the gap timer running while receiving.
// - Transmit count comes from the output length byte, any mode.
// - Default send: transmit only when the output ID changes.
// - Auto send: transmit every sending period, ID ignored.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "sfb_consts.svh"

module sfb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  input wire logic [W-1:0] in_data, // Write word
  output logic out_valid, // Not empty
  input wire logic out_ready, // Read request
  output logic [W-1:0] out_data // Head word
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sfb_fifo_st_t;
  sfb_fifo_st_t s, n;
  logic full, empty;

  assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
  assign empty = s.wp == s.rp;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s.mem[s.rp[AW-1:0]];

  always_comb begin
    n = s;
    if (in_valid && !full) begin
      n.mem[s.wp[AW-1:0]] = in_data;
      n.wp = s.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      n.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule // sfb_fifo

////////////////////////////////////////////////////////////////////////////////

module sfb_bridge #(
  parameter logic [16:0] CYC_PER_MS = 17'(`SFB_CYC_MS)
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic rx_valid, // Serial byte in valid
  output logic rx_ready, // Serial byte in ready
  input wire logic [7:0] rx_data, // Serial byte in
  output logic tx_valid, // Serial byte out valid
  input wire logic tx_ready, // Serial byte out ready
  output logic [7:0] tx_data // Serial byte out
);
  sfb_pkg::sfb_state_t s, n;
  sfb_pkg::sfb_byte_t f;
  logic f_ready, take, tick, tmo, push, crc_use, crc_ok, pub, per_hit, fire;
  logic [7:0] plen_c;
  logic [7:0] olen;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction

  // One byte of the input area as the fieldbus side sees it
  function automatic logic [7:0] in_byte(input sfb_pkg::sfb_state_t t, input logic [4:0] k);
    logic [7:0] j;
    j = {3'h0, k} - (t.len_en ? 8'h02 : 8'h01);
    if (k == 5'h00) begin
      return t.in_id;
    end else if (k == 5'h01 && t.len_en) begin
      return t.plen;
    end else if (j < t.plen) begin
      return t.pbuf[j[4:0]];
    end
    return 8'h00;
  endfunction

  function automatic logic in_area(input logic [11:0] a, input logic [11:0] base);
    return a >= base && a <= base + `SFB_AREA_HI;
  endfunction

  sfb_fifo #(.W(8), .D(8)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_data),
    .out_valid(f.valid),
    .out_ready(f_ready),
    .out_data(f.data)
  );

  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign pready = 1'b1;
  assign tx_valid = s.tx.valid;
  assign tx_data = s.tx.data;
  assign f_ready = s.rx_st != sfb_pkg::RX_CHECK;
  assign take = f.valid && f_ready;
  assign tick = s.pre == CYC_PER_MS - 17'h1;
  assign tmo = s.rx_st == sfb_pkg::RX_COLLECT && s.gap_cnt >= s.gap_ms;
  assign crc_use = s.crc_en && s.mode != sfb_pkg::MODE_DELIM;
  assign crc_ok = s.cnt >= 8'h03 && s.crc == {s.hold[7:0], s.hold[15:8]};
  assign plen_c = crc_use ? s.cnt - 8'h02 : s.cnt;
  assign pub = s.rx_st == sfb_pkg::RX_CHECK && !s.ovf && (!crc_use || crc_ok);
  assign per_hit = s.auto_en && tick && s.per_cnt + 16'h1 >= s.per_ms;
  assign olen = s.obuf[1] > `SFB_TX_MAX ? `SFB_TX_MAX : s.obuf[1];
  assign fire = s.auto_en ? per_hit : s.obuf[0] != s.last_id;

  always_comb begin
    n = s;
    push = 1'b0;
    n.pre = tick ? 17'h0 : s.pre + 17'h1;
    ////////////////////////////////////////////////////////////////////////////
    // Register bus: read data latched in setup, writes in access
    if (psel && !penable) begin
      n.pslverr = !(paddr[1:0] == 2'b00 && (paddr <= `SFB_A_STAT
                  || in_area(paddr, `SFB_A_IN) || in_area(paddr, `SFB_A_OUT)));
      n.prdata = 32'h0;
      if (!pwrite) begin
        unique case (paddr)
          `SFB_A_CTRL: n.prdata = {27'h0, s.auto_en, s.len_en, s.crc_en, s.mode};
          `SFB_A_GAP: n.prdata = {16'h0, s.gap_ms};
          `SFB_A_FLEN: n.prdata = {24'h0, s.flen};
          `SFB_A_DELIM: n.prdata = {16'h0, s.edel, s.sdel};
          `SFB_A_PER: n.prdata = {16'h0, s.per_ms};
          `SFB_A_STAT: n.prdata = {s.drops, 7'h0, s.tx_st == sfb_pkg::TX_SEND,
                                   s.plen, s.in_id};
          default: begin
            for (int i = 0; i < 4; i++) begin
              if (in_area(paddr, `SFB_A_IN)) begin
                n.prdata[8*i +: 8] = in_byte(s, {paddr[4:2], 2'(i)});
              end else if (in_area(paddr, `SFB_A_OUT)) begin
                n.prdata[8*i +: 8] = s.obuf[{paddr[4:2], 2'(i)}];
              end
            end
          end
        endcase
      end
    end
    if (psel && penable && pwrite && !s.pslverr) begin
      unique case (paddr)
        `SFB_A_CTRL: begin
          n.mode = pwdata[1:0] == 2'h3 ? sfb_pkg::MODE_GAP : sfb_pkg::sfb_mode_t'(pwdata[1:0]);
          n.crc_en = pwdata[`SFB_B_CRC];
          n.len_en = pwdata[`SFB_B_LEN];
          n.auto_en = pwdata[`SFB_B_AUTO];
        end
        `SFB_A_GAP: n.gap_ms = pwdata[15:0];
        `SFB_A_FLEN: n.flen = pwdata[7:0];
        `SFB_A_DELIM: {n.edel, n.sdel} = pwdata[15:0];
        `SFB_A_PER: n.per_ms = pwdata[15:0];
        default: begin
          if (in_area(paddr, `SFB_A_OUT)) begin
            for (int i = 0; i < 4; i++) begin
              n.obuf[{paddr[4:2], 2'(i)}] = pwdata[8*i +: 8];
            end
          end
        end
      endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // Receive framing
    if (s.rx_st == sfb_pkg::RX_COLLECT && tick) begin
      n.gap_cnt = s.gap_cnt + 16'h1;
    end
    unique case (s.rx_st)
      sfb_pkg::RX_HUNT: begin
        if (take) begin
          n.cnt = 8'h00;
          n.ovf = 1'b0;
          n.crc = 16'hFFFF;
          n.hold = 16'h0;
          n.gap_cnt = 16'h0;
          if (s.mode == sfb_pkg::MODE_DELIM) begin
            if (f.data == s.sdel) begin
              n.rx_st = sfb_pkg::RX_COLLECT;
            end
          end else begin
            push = 1'b1;
            n.rx_st = sfb_pkg::RX_COLLECT;
          end
        end
      end
      sfb_pkg::RX_COLLECT: begin
        if (take) begin
          n.gap_cnt = 16'h0;
          if (s.mode == sfb_pkg::MODE_DELIM && f.data == s.edel) begin
            n.rx_st = sfb_pkg::RX_CHECK;
          end else begin
            push = 1'b1;
          end
        end else if (tmo) begin
          if (s.mode == sfb_pkg::MODE_GAP) begin
            n.rx_st = sfb_pkg::RX_CHECK;
          end else begin
            n.rx_st = sfb_pkg::RX_HUNT;
            n.drops = s.drops + 8'h01;
          end
        end
      end
      sfb_pkg::RX_CHECK: begin
        n.rx_st = sfb_pkg::RX_HUNT;
        if (pub) begin
          n.pbuf = s.rbuf;
          n.plen = plen_c;
          n.in_id = s.in_id + 8'h01;
        end else begin
          n.drops = s.drops + 8'h01;
        end
      end
      default: n.rx_st = sfb_pkg::RX_HUNT;
    endcase
    if (push) begin
      if (n.cnt < 8'(`SFB_AREA)) begin
        n.rbuf[n.cnt[4:0]] = f.data;
      end else begin
        n.ovf = 1'b1;
      end
      if (n.cnt >= 8'h02) begin
        n.crc = crc_byte(n.crc, n.hold[15:8]);
      end
      n.hold = {n.hold[7:0], f.data};
      n.cnt = n.cnt == 8'hFF ? 8'hFF : n.cnt + 8'h01;
      if (s.mode == sfb_pkg::MODE_FIXED && n.cnt == s.flen) begin
        n.rx_st = sfb_pkg::RX_CHECK;
      end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Transmit from the output area
    if (s.auto_en && tick) begin
      n.per_cnt = per_hit ? 16'h0 : s.per_cnt + 16'h1;
    end
    unique case (s.tx_st)
      sfb_pkg::TX_IDLE: begin
        if (fire) begin
          n.last_id = s.obuf[0];
          if (olen != 8'h00) begin
            n.tlen = olen[5:0];
            n.tidx = 6'h0;
            n.tx = '{valid: 1'b1, data: s.obuf[2]};
            n.tx_st = sfb_pkg::TX_SEND;
          end
        end
      end
      sfb_pkg::TX_SEND: begin
        if (tx_ready) begin
          if (s.tidx + 6'h1 == s.tlen) begin
            n.tx.valid = 1'b0;
            n.tx_st = sfb_pkg::TX_IDLE;
          end else begin
            n.tidx = s.tidx + 6'h1;
            n.tx.data = s.obuf[5'(s.tidx + 6'h3)];
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.mode <= sfb_pkg::MODE_GAP;
      s.rx_st <= sfb_pkg::RX_HUNT;
      s.tx_st <= sfb_pkg::TX_IDLE;
      s.gap_ms <= `SFB_RST_GAP;
      s.per_ms <= `SFB_RST_PER;
      s.flen <= `SFB_RST_FLEN;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_id_step: assert property (pub |=> s.in_id == $past(s.in_id) + 8'h01)
    else $error("input id did not advance by one");
  a_drop_hold: assert property (!pub |=> $stable(s.in_id) && $stable(s.pbuf))
    else $error("input area changed without a good frame");
  a_crc_drop: assert property (s.rx_st == sfb_pkg::RX_CHECK && crc_use && !crc_ok
    |=> $stable(s.plen) && $stable(s.in_id))
    else $error("frame with bad CRC was published");
  a_fixed_end: assert property (push && s.mode == sfb_pkg::MODE_FIXED && n.cnt == s.flen
    |=> s.rx_st == sfb_pkg::RX_CHECK)
    else $error("fixed length frame did not close at count");
  a_gap_close: assert property (tmo && !take && s.mode == sfb_pkg::MODE_GAP
    |=> s.rx_st == sfb_pkg::RX_CHECK ##1 s.rx_st == sfb_pkg::RX_HUNT)
    else $error("gap timeout did not close the frame");
  a_delim_drop: assert property (tmo && !take && s.mode == sfb_pkg::MODE_DELIM
    |=> s.rx_st == sfb_pkg::RX_HUNT && s.drops == $past(s.drops) + 8'h01)
    else $error("delimiter frame not dropped on timeout");
  a_pad_zero: assert property (s.plen < 8'h1C |-> in_byte(s, 5'h1F) == 8'h00)
    else $error("padding byte not zero");
  a_len_off: assert property (!s.len_en && s.plen != 8'h00 |-> in_byte(s, 5'h01) == s.pbuf[0])
    else $error("length byte shown while option is off");
  a_no_resend: assert property (s.tx_st == sfb_pkg::TX_IDLE && !s.auto_en
    && s.obuf[0] == s.last_id |=> !s.tx.valid)
    else $error("transmit started without id change");
  a_tx_len: assert property ($rose(s.tx.valid) |-> s.tlen == $past(olen[5:0])
    && s.tx.data == $past(s.obuf[2]))
    else $error("transmit length or first byte wrong");
  a_auto_go: assert property (s.tx_st == sfb_pkg::TX_IDLE && per_hit && olen != 8'h00
    |=> s.tx.valid)
    else $error("auto send did not start on period");

  c_publish: cover property (pub);
  c_drop: cover property (s.rx_st == sfb_pkg::RX_CHECK && !pub);
  c_delim: cover property (pub && s.mode == sfb_pkg::MODE_DELIM);
  c_tx_done: cover property (s.tx_st == sfb_pkg::TX_SEND ##1 s.tx_st == sfb_pkg::TX_IDLE);
endmodule // sfb_bridge

/* File: rtl/sfb_consts.svh */
// Offsets, field positions, reset values and timing counts of the frame bridge
`ifndef SFB_CONSTS_SVH
`define SFB_CONSTS_SVH
`define SFB_A_CTRL 12'h000
`define SFB_A_GAP 12'h004
`define SFB_A_FLEN 12'h008
`define SFB_A_DELIM 12'h00C
`define SFB_A_PER 12'h010
`define SFB_A_STAT 12'h014
`define SFB_A_IN 12'h100
`define SFB_A_OUT 12'h200
`define SFB_AREA_HI 12'h01C
`define SFB_AREA 32
`define SFB_TX_MAX 8'h1E
`define SFB_B_CRC 2
`define SFB_B_LEN 3
`define SFB_B_AUTO 4
`define SFB_RST_GAP 16'h000A
`define SFB_RST_PER 16'h03E8
`define SFB_RST_FLEN 8'h01
`define SFB_MS_NS 1000000
`define SFB_CLK_NS 8
`define SFB_CYC_MS (`SFB_MS_NS / `SFB_CLK_NS)
`endif

/* File: rtl/sfb_pkg.sv */
// Types of the frame bridge
package sfb_pkg;
  typedef enum logic [1:0] {MODE_GAP, MODE_FIXED, MODE_DELIM} sfb_mode_t;
  typedef enum logic [1:0] {RX_HUNT, RX_COLLECT, RX_CHECK} sfb_rx_t;
  typedef enum logic {TX_IDLE, TX_SEND} sfb_tx_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sfb_byte_t;
  typedef struct packed {
    sfb_mode_t mode;
    logic crc_en;
    logic len_en;
    logic auto_en;
    logic [15:0] gap_ms;
    logic [15:0] per_ms;
    logic [7:0] flen;
    logic [7:0] sdel;
    logic [7:0] edel;
    logic [16:0] pre;
    logic [15:0] gap_cnt;
    logic [15:0] per_cnt;
    sfb_rx_t rx_st;
    logic [7:0] cnt;
    logic ovf;
    logic [15:0] crc;
    logic [15:0] hold;
    logic [31:0][7:0] rbuf;
    logic [31:0][7:0] pbuf;
    logic [31:0][7:0] obuf;
    logic [7:0] plen;
    logic [7:0] in_id;
    logic [7:0] drops;
    logic [7:0] last_id;
    sfb_tx_t tx_st;
    logic [5:0] tidx;
    logic [5:0] tlen;
    sfb_byte_t tx;
    logic [31:0] prdata;
    logic pslverr;
  } sfb_state_t;
endpackage

/* File: verification/sfb_serial_dev.sv */
// Serial device model: byte source with level handshake and a stalling sink
`timescale 1ns/1ps

module sfb_serial_dev (
  input wire logic pclk, // Clock
  output logic rx_valid, // Byte to bridge valid
  input wire logic rx_ready, // Bridge takes byte
  output logic [7:0] rx_data, // Byte to bridge
  input wire logic tx_valid, // Byte from bridge valid
  output logic tx_ready // Sink ready, random stalls
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  // Sink stalls about one cycle in three
  always @(posedge pclk) begin
    tx_ready <= ($urandom % 3) != 0;
  end

  // Caller sends start byte, contents, then end byte in delimiter mode
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge pclk);
    while (rx_ready !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    rx_valid <= 1'b0;
    // Released line shows the inverse of the last byte
    rx_data <= ~b;
  endtask
endmodule // sfb_serial_dev

/* File: verification/tb_serial_fieldbus_frame_bridge.sv */
// Self-checking testbench of the frame bridge
`timescale 1ns/1ps
`include "sfb_consts.svh"

module tb_serial_fieldbus_frame_bridge;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lw0, lw1, t, w;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data, id, drops;
  logic [7:0] q[$];
  logic [7:0] exp_q[$];
  logic [15:0] c;
  int n_errors, n_compared;

  sfb_bridge #(.CYC_PER_MS(17'h00014)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data));

  sfb_serial_dev u_dev (.pclk(pclk), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  always #4 pclk = ~pclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      check("apb ready", pready, 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] crc16(input int n);
    logic [15:0] r;
    r = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      r = r ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
      end
    end
    return r;
  endfunction

  task automatic rnd(input int n);
    q.delete();
    repeat (n) q.push_back(8'($urandom));
  endtask

  // Sends q, lets the gap expire, then checks id, drop count and input area
  task automatic frame(input logic ok, input logic [31:0] w0, input logic [31:0] w1);
    foreach (q[i]) u_dev.send(q[i]);
    repeat (80) @(posedge pclk);
    if (ok) begin
      id++;
      lw0 = {w0[31:8], id};
      lw1 = w1;
    end else begin
      drops++;
    end
    apb(1'b0, `SFB_A_STAT, 32'h0);
    check("status id", rd[7:0], id);
    check("status drops", rd[31:24], drops);
    apb(1'b0, `SFB_A_IN, 32'h0);
    check("in word0", rd, lw0);
    apb(1'b0, `SFB_A_IN + 12'h004, 32'h0);
    check("in word1", rd, lw1);
  endtask

  task automatic tx_done;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    check("tx pending", 32'(exp_q.size()), 32'h0);
  endtask

  // Each accepted serial byte is matched against the oldest note
  always @(negedge pclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) check("tx unexpected", 32'h1, 32'h0);
      else check("tx byte", tx_data, exp_q.pop_front());
    end
  end

  initial begin
    #200000;
    n_errors++;
    complete_run();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {id, drops, lw0, lw1, n_errors, n_compared} = '0;
    void'($urandom(70));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SFB_A_GAP, 32'h0);
    check("gap reset", rd, {16'h0000, `SFB_RST_GAP});
    apb(1'b0, `SFB_A_PER, 32'h0);
    check("period reset", rd, {16'h0000, `SFB_RST_PER});
    apb(1'b0, 12'h300, 32'h0);
    check("unmapped error", err, 1'b1);
    // Payloads stay within the 32-byte areas
    apb(1'b1, `SFB_A_GAP, 32'h2);
    // Mode code 3 falls back to gap mode
    apb(1'b1, `SFB_A_CTRL, 32'h0B);
    apb(1'b0, `SFB_A_CTRL, 32'h0);
    check("ctrl mode 3", rd, 32'h08);
    q = '{8'h11, 8'h22};
    frame(1'b1, 32'h22110200, 32'h0);
    apb(1'b1, `SFB_A_CTRL, 32'h00);
    q = '{8'h33, 8'h44, 8'h55};
    frame(1'b1, 32'h55443300, 32'h0);
    apb(1'b1, `SFB_A_FLEN, 32'h5);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `SFB_A_CTRL, m ? 32'h0D : 32'h0C);
      for (int k = 0; k < 2; k++) begin
        rnd(3);
        c = crc16(3);
        q.push_back(c[7:0]);
        q.push_back(k ? ~c[15:8] : c[15:8]);
        frame(k == 0, {q[1], q[0], 8'h03, 8'h00}, {24'h0, q[2]});
      end
    end
    apb(1'b1, `SFB_A_FLEN, 32'h4);
    apb(1'b1, `SFB_A_CTRL, 32'h09);
    rnd(4);
    frame(1'b1, {q[1], q[0], 8'h04, 8'h00}, {16'h0, q[3], q[2]});
    rnd(3);
    frame(1'b0, 32'h0, 32'h0);
    apb(1'b1, `SFB_A_DELIM, 32'h0000FEFF);
    apb(1'b1, `SFB_A_CTRL, 32'h0A);
    q = '{8'hFF, 8'hA1, 8'hA2, 8'hFE};
    frame(1'b1, 32'hA2A10200, 32'h0);
    q = '{8'hA5, 8'hFF, 8'hB1, 8'hFE};
    frame(1'b1, 32'h00B10100, 32'h0);
    q = '{8'hFF, 8'hA1};
    frame(1'b0, 32'h0, 32'h0);
    apb(1'b1, `SFB_A_CTRL, 32'h00);
    t = $urandom;
    apb(1'b1, `SFB_A_OUT + 12'h004, t);
    w = {8'($urandom), 8'($urandom), 8'h05, 8'h10};
    exp_q = '{w[23:16], w[31:24], t[7:0], t[15:8], t[23:16]};
    apb(1'b1, `SFB_A_OUT, w);
    tx_done();
    apb(1'b1, `SFB_A_OUT, w);
    repeat (100) @(posedge pclk);
    apb(1'b1, `SFB_A_OUT, {w[31:16], 16'h0011});
    repeat (100) @(posedge pclk);
    w[15:0] = 16'h0112;
    exp_q = '{w[23:16]};
    apb(1'b1, `SFB_A_OUT, w);
    tx_done();
    apb(1'b1, `SFB_A_PER, 32'h5);
    exp_q = '{w[23:16], w[23:16]};
    apb(1'b1, `SFB_A_CTRL, 32'h10);
    tx_done();
    apb(1'b1, `SFB_A_CTRL, 32'h00);
    repeat (200) @(posedge pclk);
    complete_run();
  end
endmodule // tb_serial_fieldbus_frame_bridge
